// >>> logic/ssc_channel_one.sv
// Synchronous serial channel: 8/16-bit LSB-first shifter with Wishbone regs.
// Assumes pins are synchronous to clk_sys_i and a single-cycle bus master.
module ssc_channel_one (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [ssc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     serial_clock_pin_i,
    output logic                          serial_clock_pin_o,
    output logic                          serial_clock_pin_oe_o,
    input  wire logic                     serial_in_pin_i,
    output logic                          serial_out_pin_o,
    output logic                          irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ssc_pkg::ssc_state_type state_ff, nxt_state;
    logic [7:0]  ctrl_ff, nxt_ctrl;
    logic [15:0] sr_ff, nxt_sr;
    logic [4:0]  cnt_ff, nxt_cnt;
    logic [1:0]  istat_ff, nxt_istat;
    logic [1:0]  imask_ff, nxt_imask;
    logic        sck_ff, nxt_sck;
    logic        sck_oe_ff, nxt_sck_oe;
    logic        so_ff, nxt_so;
    logic        ovr_ff, nxt_ovr;
    logic        prev_ff, nxt_prev;
    logic        irq_ff, nxt_irq;
    logic        ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic        tick, restart, ext_src, is16;
    logic        fall_e, rise_e, ovr_evt, done, commit;
    logic        wr_ctrl, wr_stat, wr_up, wr_lo, wr_is, wr_im;
    logic [15:0] idx;
    logic [7:0]  wd;
    logic [7:0]  rdata;

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    ssc_prescaler #(
        .CNT_W    (ssc_pkg::PRE_W)
    ) u_pre (
        .clk_sys_i(clk_sys_i),
        .rst_n_i  (rst_n_i),
        .restart_i(restart),
        .sel_i    (ctrl_ff[ssc_pkg::CTRL_DIV_HI:0]),
        .tick_o   (tick)
    );

    // ------------------------------------------------------------------
    // Bus decode: ack one cycle after request, write at the acked edge
    // ------------------------------------------------------------------
    always_comb begin
        idx     = wb_adr_i[ssc_pkg::ADR_W-1:2];
        wd      = wb_dat_i[7:0];
        commit  = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0];
        wr_ctrl = commit & (idx == ssc_pkg::IDX_CTRL);
        wr_stat = commit & (idx == ssc_pkg::IDX_STAT);
        wr_up   = commit & (idx == ssc_pkg::IDX_UPPER);
        wr_lo   = commit & (idx == ssc_pkg::IDX_LOWER);
        wr_is   = commit & (idx == ssc_pkg::IDX_IRQ_STAT);
        wr_im   = commit & (idx == ssc_pkg::IDX_IRQ_MASK);
        case (idx)
            ssc_pkg::IDX_CTRL:     rdata = ctrl_ff;
            ssc_pkg::IDX_STAT:     rdata = {1'b1, so_ff, ovr_ff, 4'h0,
                                            state_ff == ssc_pkg::ST_RUN};
            ssc_pkg::IDX_UPPER:    rdata = sr_ff[15:8];
            ssc_pkg::IDX_LOWER:    rdata = sr_ff[7:0];
            ssc_pkg::IDX_IRQ_STAT: rdata = {6'h00, istat_ff};
            ssc_pkg::IDX_IRQ_MASK: rdata = {6'h00, imask_ff};
            default:               rdata = 8'h00;
        endcase
        nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
        nxt_dat = nxt_ack ? {24'h000000, rdata} : 32'h00000000;
    end

    // ------------------------------------------------------------------
    // Transfer engine and register next values
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state  = state_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_sr     = sr_ff;
        nxt_cnt    = cnt_ff;
        nxt_sck    = sck_ff;
        nxt_sck_oe = sck_oe_ff;
        nxt_so     = so_ff;
        nxt_imask  = imask_ff;
        nxt_prev   = serial_clock_pin_i;
        restart    = 1'b0;
        done       = 1'b0;
        ext_src    = ctrl_ff[ssc_pkg::CTRL_SRC];
        is16       = ctrl_ff[ssc_pkg::CTRL_MODE_HI:ssc_pkg::CTRL_MODE_LO] == ssc_pkg::MODE_16;
        // Edges from external pin or from the internal clock level
        fall_e     = ext_src ? (prev_ff & ~serial_clock_pin_i) : (tick & sck_ff);
        rise_e     = ext_src ? (~prev_ff & serial_clock_pin_i) : (tick & ~sck_ff);
        ovr_evt    = 1'b0;
        case (state_ff)
            ssc_pkg::ST_IDLE: begin
                nxt_sck = 1'b1;
                ovr_evt = ext_src & fall_e;
            end
            ssc_pkg::ST_RUN: begin
                if (!ext_src && tick) begin
                    nxt_sck = ~sck_ff;
                end
                if (fall_e) begin
                    nxt_so = sr_ff[0];
                end
                if (rise_e) begin
                    if (is16) begin
                        nxt_sr = {serial_in_pin_i, sr_ff[15:1]};
                    end else begin
                        nxt_sr[7:0] = {serial_in_pin_i, sr_ff[7:1]};
                    end
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == (is16 ? ssc_pkg::LAST_16 : ssc_pkg::LAST_8)) begin
                        done      = 1'b1;
                        nxt_state = ssc_pkg::ST_IDLE;
                    end
                end
            end
            ssc_pkg::ST_CONT: begin
                if (tick) begin
                    nxt_sck = ~sck_ff;
                end
            end
            default: begin
                nxt_state = ssc_pkg::ST_IDLE;
            end
        endcase
        // Software writes take priority over the engine
        if (wr_stat) begin
            nxt_so = wd[ssc_pkg::STAT_SOL];
            if (wd[ssc_pkg::STAT_STF] && state_ff == ssc_pkg::ST_IDLE) begin
                nxt_state = ssc_pkg::ST_RUN;
                nxt_cnt   = 5'h00;
                nxt_sck   = 1'b1;
                restart   = 1'b1;
            end
        end
        if (wr_up) begin
            nxt_sr[15:8] = wd;
        end
        if (wr_lo) begin
            nxt_sr[7:0] = wd;
        end
        if (wr_im) begin
            nxt_imask = wd[1:0];
        end
        if (wr_ctrl) begin
            nxt_ctrl   = wd;
            done       = 1'b0; // Aborted transfer raises no done event
            nxt_sck    = 1'b1;
            nxt_cnt    = 5'h00;
            restart    = 1'b1;
            nxt_sck_oe = ~wd[ssc_pkg::CTRL_SRC] |
                         (wd[ssc_pkg::CTRL_MODE_HI:ssc_pkg::CTRL_MODE_LO] == ssc_pkg::MODE_CONT);
            // A write stops any transfer; data pins stay idle in continuous mode
            nxt_state  = (wd[ssc_pkg::CTRL_MODE_HI:ssc_pkg::CTRL_MODE_LO] == ssc_pkg::MODE_CONT) ?
                         ssc_pkg::ST_CONT : ssc_pkg::ST_IDLE;
        end
        // Set wins over clear for both flags
        nxt_ovr   = ovr_evt | (ovr_ff & ~(wr_stat & ~wd[ssc_pkg::STAT_OVERRUN_ERROR_FLAG]));
        nxt_istat = {ovr_evt, done} | (istat_ff & ~(wr_is ? wd[1:0] : 2'h0));
        nxt_irq   = |(nxt_istat & nxt_imask);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff  <= ssc_pkg::ST_IDLE;
            ctrl_ff   <= ssc_pkg::CTRL_RST;
            sr_ff     <= 16'h0000;
            cnt_ff    <= 5'h00;
            sck_ff    <= 1'b1;
            sck_oe_ff <= 1'b1;
            so_ff     <= ssc_pkg::STAT_RST[ssc_pkg::STAT_SOL];
            ovr_ff    <= ssc_pkg::STAT_RST[ssc_pkg::STAT_OVERRUN_ERROR_FLAG];
            prev_ff   <= 1'b1;
            istat_ff  <= ssc_pkg::IRQ_RST;
            imask_ff  <= ssc_pkg::IRQ_RST;
            irq_ff    <= 1'b0;
            ack_ff    <= 1'b0;
            dat_ff    <= 32'h00000000;
        end else begin
            state_ff  <= nxt_state;
            ctrl_ff   <= nxt_ctrl;
            sr_ff     <= nxt_sr;
            cnt_ff    <= nxt_cnt;
            sck_ff    <= nxt_sck;
            sck_oe_ff <= nxt_sck_oe;
            so_ff     <= nxt_so;
            ovr_ff    <= nxt_ovr;
            prev_ff   <= nxt_prev;
            istat_ff  <= nxt_istat;
            imask_ff  <= nxt_imask;
            irq_ff    <= nxt_irq;
            ack_ff    <= nxt_ack;
            dat_ff    <= nxt_dat;
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o              = ack_ff;
    assign wb_dat_o              = dat_ff;
    assign serial_clock_pin_o    = sck_ff;
    assign serial_clock_pin_oe_o = sck_oe_ff;
    assign serial_out_pin_o      = so_ff;
    assign irq_o                 = irq_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_ctrl_stop;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_ctrl && state_ff == ssc_pkg::ST_RUN |=> state_ff != ssc_pkg::ST_RUN && istat_ff[0] == $past(istat_ff[0]);
    endproperty
    a_ctrl_stop: assert property (p_ctrl_stop) else $error("Control write did not stop transfer");

    property p_stat_bit7;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wb_cyc_i && wb_stb_i && !ack_ff && !wb_we_i && idx == ssc_pkg::IDX_STAT |=> wb_dat_o[7] && wb_ack_o;
    endproperty
    a_stat_bit7: assert property (p_stat_bit7) else $error("Status bit 7 not read as one");

    property p_sol_write;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_stat && state_ff == ssc_pkg::ST_IDLE |=> serial_out_pin_o == $past(wd[ssc_pkg::STAT_SOL]);
    endproperty
    a_sol_write: assert property (p_sol_write) else $error("Output level write not applied");

    property p_overrun_error_flag_one;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_stat && !ovr_ff && !ovr_evt |=> !ovr_ff;
    endproperty
    a_overrun_error_flag_one: assert property (p_overrun_error_flag_one) else $error("Overrun set by a software write");

    property p_done_irq;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(state_ff == ssc_pkg::ST_RUN) && !$past(wr_ctrl) |-> istat_ff[0];
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("Completion gave no interrupt status");

    property p_cont_clk;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        state_ff == ssc_pkg::ST_CONT && tick && !wr_ctrl |=> serial_clock_pin_o != $past(serial_clock_pin_o) && serial_clock_pin_oe_o;
    endproperty
    a_cont_clk: assert property (p_cont_clk) else $error("Continuous clock stalled");

    property p_ext_ovr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        state_ff == ssc_pkg::ST_IDLE && ext_src && prev_ff && !serial_clock_pin_i && !wr_up && !wr_lo
        |=> ovr_ff && $stable(sr_ff);
    endproperty
    a_ext_ovr: assert property (p_ext_ovr) else $error("Late external pulse missed overrun");

    property p_lsb_out;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        state_ff == ssc_pkg::ST_RUN && fall_e && !wr_stat |=> serial_out_pin_o == $past(sr_ff[0]);
    endproperty
    a_lsb_out: assert property (p_lsb_out) else $error("Data pin not driven with low bit");

    property p_hold_last;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        state_ff == ssc_pkg::ST_IDLE && !wr_stat ##1 state_ff == ssc_pkg::ST_IDLE |-> $stable(serial_out_pin_o);
    endproperty
    a_hold_last: assert property (p_hold_last) else $error("Idle data pin changed on its own");

    property p_busy_start;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_stat && wd[ssc_pkg::STAT_STF] && state_ff == ssc_pkg::ST_IDLE && !wr_ctrl |=> state_ff == ssc_pkg::ST_RUN [*2];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("Start flag did not hold busy");

endmodule : ssc_channel_one

// >>> include/ssc_pkg.sv
// Constants, field layout and states of the synchronous serial channel.
// Assumes a 32-bit classic Wishbone register bus and one system clock.
package ssc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int          ADR_W         = 18;
    localparam logic [15:0] IDX_CTRL      = 16'hffa0;
    localparam logic [15:0] IDX_STAT      = 16'hffa1;
    localparam logic [15:0] IDX_UPPER     = 16'hffa2;
    localparam logic [15:0] IDX_LOWER     = 16'hffa3;
    localparam logic [15:0] IDX_IRQ_STAT  = 16'hffa4;
    localparam logic [15:0] IDX_IRQ_MASK  = 16'hffa5;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          CTRL_MODE_HI  = 7;
    localparam int          CTRL_MODE_LO  = 6;
    localparam int          CTRL_SRC      = 3;
    localparam int          CTRL_DIV_HI   = 2;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam int          STAT_RSV      = 7;
    localparam int          STAT_SOL      = 6;
    localparam int          STAT_OVERRUN_ERROR_FLAG     = 5;
    localparam int          STAT_STF      = 0;
    localparam logic [7:0]  STAT_RST      = 8'h80;
    localparam int          IRQ_DONE      = 0;
    localparam int          IRQ_OVR       = 1;
    localparam logic [1:0]  IRQ_RST       = 2'h0;

    // ------------------------------------------------------------------
    // Modes, lengths and prescaler
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_8        = 2'h0;
    localparam logic [1:0]  MODE_16       = 2'h1;
    localparam logic [1:0]  MODE_CONT     = 2'h2;
    localparam logic [4:0]  LAST_8        = 5'h07;
    localparam logic [4:0]  LAST_16       = 5'h0f;
    localparam int          PRE_W         = 9;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_CONT = 3'b100
    } ssc_state_type;

    // Half-period mask: ratios 1024,256,64,32,16,8,4,2 for codes 0..7
    function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    div_mask = 9'h1ff;
            3'h1:    div_mask = 9'h07f;
            3'h2:    div_mask = 9'h01f;
            3'h3:    div_mask = 9'h00f;
            3'h4:    div_mask = 9'h007;
            3'h5:    div_mask = 9'h003;
            3'h6:    div_mask = 9'h001;
            default: div_mask = 9'h000;
        endcase
    endfunction : div_mask

endpackage : ssc_pkg

// >>> logic/ssc_prescaler.sv
// Prescaler that gives a one-cycle tick per serial clock half period.
// Assumes the selector is stable between restarts.
module ssc_prescaler #(
    parameter int CNT_W = ssc_pkg::PRE_W
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       restart_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (CNT_W != ssc_pkg::PRE_W) begin : g_bad_width
        $error("Prescaler width must match the divider table");
    end

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] mask;

    // Tick when all bits under the mask are set
    always_comb begin
        mask    = ssc_pkg::div_mask(sel_i);
        tick_o  = ((cnt_ff & mask) == mask);
        nxt_cnt = restart_i ? '0 : cnt_ff + 1'b1;
    end

    // Free-running count, restarted with each transfer
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule : ssc_prescaler

// >>> verification/ssc_peer_model.sv
// External serial peer: takes a word in on rising clock, sends its own word.
// Assumes the clock pin is resolved outside and all pins move on clk_sys_i.
module ssc_peer_model (
    input  wire logic clk_sys_i,
    input  wire logic sck_i,
    input  wire logic so_i,
    output logic      si_o,
    output logic      sck_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic [4:0]  bit_cnt;
    logic [4:0]  frame_len;

    // Idle levels: clock stands high, data line keeps changing
    initial begin
        tx_word   = 16'h0000;
        rx_word   = 16'h0000;
        bit_cnt   = 5'h00;
        frame_len = 5'h00;
        si_o      = 1'b0;
        sck_o     = 1'b1;
    end

    // Capture on the rising line clock, with no sampling lag
    always @(posedge sck_i) begin
        rx_word <= {so_i, rx_word[15:1]};
        bit_cnt <= bit_cnt + 5'h01;
    end

    // Next bit right at the falling line clock, so even a one-cycle half period holds
    always @(negedge sck_i) begin
        if (bit_cnt != 5'h00 && bit_cnt < frame_len) begin
            si_o <= tx_word[bit_cnt[3:0]];
        end
    end

    // First bit stands before the first clock; inverse level outside frames
    always @(posedge clk_sys_i) begin
        if (bit_cnt >= frame_len) begin
            si_o <= ~si_o;
        end else if (bit_cnt == 5'h00) begin
            si_o <= tx_word[0];
        end
    end

    // Arms a frame just after a clock edge
    task automatic load(input logic [15:0] word, input logic [4:0] len);
        tx_word   <= word;
        frame_len <= len;
        bit_cnt   <= 5'h00;
    endtask : load

    // Drives clock pulses when the channel takes its clock from outside
    task automatic pulse(input int n, input int half);
        for (int k = 0; k < n; k++) begin
            @(posedge clk_sys_i);
            sck_o <= 1'b0;
            repeat (half) @(posedge clk_sys_i);
            sck_o <= 1'b1;
            repeat (half - 1) @(posedge clk_sys_i);
        end
    endtask : pulse
endmodule : ssc_peer_model

// >>> verification/test_sync_serial_channel_8_16.sv
// Self-checking bench for the serial channel, with a peer on its pins.
// Assumes the register map and one-cycle bus answer of the channel.
module test_sync_serial_channel_8_16;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF [8] = '{512, 128, 32, 16, 8, 4, 2, 1};
    logic        clk_sys_i  = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        wb_cyc     = 1'b0;
    logic        wb_stb     = 1'b0;
    logic        wb_we      = 1'b0;
    logic [3:0]  wb_sel     = 4'h1;
    logic [17:0] wb_adr     = 18'h00000;
    logic [31:0] wb_dat     = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sck_o;
    logic        sck_oe;
    logic        peer_sck;
    logic        si;
    logic        so;
    logic        irq;
    wire         sck_w      = sck_oe ? sck_o : peer_sck;
    integer      seed       = 32'hf19d;
    int          num_errors = 0;
    int          compares   = 0;
    int          cycles     = 0;
    int          lo_cnt     = 0;
    int          lo_last    = 0;

    ssc_channel_one i_ssc_channel_one (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_clock_pin_i(sck_w),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe), .serial_in_pin_i(si),
        .serial_out_pin_o(so), .irq_o(irq));
    ssc_peer_model peer (.clk_sys_i(clk_sys_i), .sck_i(sck_w), .so_i(so), .si_o(si), .sck_o(peer_sck));

    // System clock, 25 ns period
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // Hang guard and length of the last low clock phase
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
        if (sck_o === 1'b0) begin
            lo_cnt <= lo_cnt + 1;
        end else if (lo_cnt != 0) begin
            lo_last <= lo_cnt;
            lo_cnt  <= 0;
        end
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // One classic bus cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h000000, wd};
        do begin
            @(posedge clk_sys_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wb

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        wb(1'b1, idx, d, unused);
    endtask : wr

    task automatic rd(input logic [15:0] idx, output logic [7:0] v);
        wb(1'b0, idx, 8'h00, v);
    endtask : rd

    task automatic rc(input string what, input logic [15:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        rd(idx, v);
        check(what, {8'h00, v}, {8'h00, exp});
    endtask : rc

    // One transfer with random data in both directions, then its checks
    task automatic xfer(input logic m16, input logic [2:0] code, input logic ext);
        logic [15:0] tx;
        logic [15:0] rx;
        logic [7:0]  v;
        logic [15:0] got;
        logic        last;
        int          n;
        tx   = 16'($random(seed));
        rx   = 16'($random(seed));
        last = m16 ? tx[15] : tx[7];
        n    = 0;
        wr(ssc_pkg::IDX_CTRL, {1'b0, m16, 2'b00, ext, code});
        wr(ssc_pkg::IDX_UPPER, tx[15:8]);
        wr(ssc_pkg::IDX_LOWER, tx[7:0]);
        peer.load(rx, m16 ? 5'h10 : 5'h08);
        wr(ssc_pkg::IDX_STAT, 8'h40);
        wr(ssc_pkg::IDX_STAT, 8'h41);
        rd(ssc_pkg::IDX_STAT, v);
        check("busy", {15'h0000, v[0]}, 16'h0001);
        check("clock pin enable", {15'h0000, sck_oe}, {15'h0000, ~ext});
        if (ext) peer.pulse(m16 ? 16 : 8, 5);
        do begin
            rd(ssc_pkg::IDX_STAT, v);
            n++;
        end while (v[0] !== 1'b0 && n < 8000);
        check("status after", {8'h00, v}, {8'h00, 1'b1, last, 6'h00});
        check("out pin", {15'h0000, so}, {15'h0000, last});
        rd(ssc_pkg::IDX_LOWER, got[7:0]);
        rd(ssc_pkg::IDX_UPPER, got[15:8]);
        check("rx data", got, m16 ? rx : {tx[15:8], rx[7:0]});
        check("peer rx", m16 ? peer.rx_word : {8'h00, peer.rx_word[15:8]}, m16 ? tx : {8'h00, tx[7:0]});
        if (!ext) check("half period", 16'(lo_last), 16'(HALF[code]));
        rc("done event", ssc_pkg::IDX_IRQ_STAT, 8'h01);
        wr(ssc_pkg::IDX_IRQ_STAT, 8'h01);
    endtask : xfer

    // Main sequence
    initial begin
        logic [7:0] v;
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rc("ctrl reset", ssc_pkg::IDX_CTRL, 8'h00);
        rc("status reset", ssc_pkg::IDX_STAT, 8'h80);
        rc("unmapped", 16'hff00, 8'h00);
        wr(ssc_pkg::IDX_CTRL, 8'h35);
        rc("scratch bits", ssc_pkg::IDX_CTRL, 8'h35);
        wr(ssc_pkg::IDX_STAT, 8'h00);
        rc("fixed bit", ssc_pkg::IDX_STAT, 8'h80);
        wr(ssc_pkg::IDX_STAT, 8'h60);
        rc("level no overrun", ssc_pkg::IDX_STAT, 8'hc0);
        check("level on pin", {15'h0000, so}, 16'h0001);
        wr(ssc_pkg::IDX_IRQ_MASK, 8'h03);
        for (int c = 0; c < 8; c++) xfer(c[0], c[2:0], 1'b0);
        xfer(1'b0, 3'h0, 1'b1);
        xfer(1'b1, 3'h0, 1'b1);
        wr(ssc_pkg::IDX_IRQ_MASK, 8'h00);
        peer.pulse(1, 5);
        rd(ssc_pkg::IDX_STAT, v);
        check("overrun set", {15'h0000, v[5]}, 16'h0001);
        rc("overrun event", ssc_pkg::IDX_IRQ_STAT, 8'h02);
        check("masked line", {15'h0000, irq}, 16'h0000);
        wr(ssc_pkg::IDX_IRQ_MASK, 8'h02);
        check("unmasked line", {15'h0000, irq}, 16'h0001);
        wr(ssc_pkg::IDX_IRQ_STAT, 8'h02);
        check("cleared line", {15'h0000, irq}, 16'h0000);
        wr(ssc_pkg::IDX_STAT, 8'h20);
        rd(ssc_pkg::IDX_STAT, v);
        check("overrun write one", {15'h0000, v[5]}, 16'h0001);
        wr(ssc_pkg::IDX_STAT, 8'h00);
        rd(ssc_pkg::IDX_STAT, v);
        check("overrun cleared", {15'h0000, v[5]}, 16'h0000);
        wr(ssc_pkg::IDX_CTRL, 8'h00);
        wr(ssc_pkg::IDX_STAT, 8'h01);
        repeat (100) @(posedge clk_sys_i);
        rd(ssc_pkg::IDX_STAT, v);
        check("busy before abort", {15'h0000, v[0]}, 16'h0001);
        wr(ssc_pkg::IDX_CTRL, 8'h00);
        rc("aborted", ssc_pkg::IDX_STAT, 8'h80);
        rc("no done event", ssc_pkg::IDX_IRQ_STAT, 8'h00);
        wr(ssc_pkg::IDX_LOWER, 8'h5a);
        wr(ssc_pkg::IDX_CTRL, 8'h86);
        wr(ssc_pkg::IDX_STAT, 8'h41);
        repeat (20) @(posedge clk_sys_i);
        check("free clock", 16'(lo_last), 16'h0002);
        check("free clock enable", {15'h0000, sck_oe}, 16'h0001);
        rc("no start", ssc_pkg::IDX_STAT, 8'hc0);
        rc("data kept", ssc_pkg::IDX_LOWER, 8'h5a);
        report_and_stop();
    end
endmodule : test_sync_serial_channel_8_16
